// [hw/sir_pkg.sv]
// Shared constants, types and register map of the supply integrity block
package sir_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 200;
   // Least low time of the pin after a watchdog underflow, in ns
   localparam int unsigned WDG_PULSE_NS = 20;
   localparam int unsigned WDG_PULSE_CYC = (WDG_PULSE_NS * CLK_MHZ + 999) / 1000;
   // Reset delay choices, in CPU cycles
   localparam int unsigned DELAY_SHORT_CYC = 256;
   localparam int unsigned DELAY_LONG_CYC = 4096;
   // Reset vector fetch phase, in CPU cycles
   localparam int unsigned FETCH_CYC = 2;
   localparam int unsigned CNT_W = 13;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] ADDR_ICS = 8'h00;
   localparam logic [7:0] ADDR_EVT_STAT = 8'h04;
   localparam logic [7:0] ADDR_EVT_MASK = 8'h08;
   localparam logic [7:0] ADDR_SEQ = 8'h0c;

   // integrity_control_status fields
   localparam int unsigned ICS_IRQ_EN_BIT = 6;
   localparam int unsigned ICS_LEVEL_BIT = 5;
   localparam int unsigned ICS_BROWNOUT_BIT = 4;
   localparam int unsigned ICS_WATCHDOG_BIT = 0;
   localparam logic [7:0] ICS_RESET = 8'h00;

   // Event status / mask layout
   localparam int unsigned EVT_W = 4;
   localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

   // AXI4-Lite responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN,
      ST_ACTIVE,
      ST_DELAY,
      ST_FETCH
   } sir_state_t;

   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_EXT,
      SRC_LVD,
      SRC_WDG
   } sir_src_t;

   typedef struct packed {
      logic warn_change;
      logic ext_reset;
      logic brownout_reset;
      logic watchdog_reset;
   } sir_evt_t;

   typedef struct packed {
      logic warn_irq_enable;
      logic warn_level_flag;
      logic brownout_reset_flag;
      logic watchdog_reset_flag;
   } sir_ics_t;

endpackage

// [hw/sir_integrity.sv]
// Supply integrity, reset sequencing and reset-cause flags with AXI4-Lite registers
`timescale 1ns/1ps
// What this block does
// R1: Watchdog underflow pulls reset pin low, minimum width
// R2: Pin held low throughout low-supply reset
// R3: Low-supply reset static while comparator says low
// R4: Warning monitor works only with detector enabled
// R5: Warning level flag read-only, tracks comparator
// R6: Enabled warning interrupt on every flag change
// R7: Entering warning service routine clears pending request
// R8: Warning interrupt needs enable and CPU unmask
// R9: Halt freezes register; warning cannot wake halt
// R10: Wait unaffected; warning interrupt wakes from wait
// R11: No warning interrupt for crossings during reset delay
// R12: Enabling while flag low-supply gives immediate interrupt
// R13: Brownout flag set by low-supply reset, write-zero clears
// R14: Watchdog flag set by watchdog, cleared by brownout
// R15: External and watchdog resets keep brownout flag
// R16: Software writes zero to reserved bits
// R17: Pin low for 256 or 4096 cycle delay
// R18: Two-cycle vector fetch before execution starts
// R19: Comparator outputs synchronised before use
module sir_integrity (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // AXI4-Lite slave
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // Analog comparators and option bits (asynchronous)
   input wire logic i_low_supply_detector,
   input wire logic i_supply_warning_monitor,
   input wire logic i_opt_detector_enable,
   input wire logic i_opt_long_delay,
   // Open-drain reset pin
   input wire logic i_reset_pin,
   output logic o_reset_pin_out,
   output logic o_reset_pin_oe,
   // CPU side (same clock)
   input wire logic i_watchdog_underflow,
   input wire logic i_halt,
   input wire logic i_wait,
   input wire logic i_irq_unmasked,
   input wire logic i_warn_isr_enter,
   output logic o_warn_irq,
   output logic o_wake_wait,
   output logic o_cpu_reset_n,
   output logic o_vector_fetch,
   output logic o_irq
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic s_lvd;
   logic s_warn;
   logic s_pin;
   logic s_opt_en;
   logic s_opt_long;

   // Two flops on every asynchronous input; stage one feeds stage two only
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync1 <= 5'h12;
         sync2 <= 5'h12;
      end else begin
         sync1 <= {i_reset_pin, i_low_supply_detector, i_supply_warning_monitor,
                   i_opt_detector_enable, i_opt_long_delay}; // [R19]
         sync2 <= sync1;
      end
   end
   assign {s_pin, s_lvd, s_warn, s_opt_en, s_opt_long} = sync2;

   // ------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------
   sir_pkg::sir_state_t state;
   sir_pkg::sir_state_t next_state;
   sir_pkg::sir_src_t src;
   sir_pkg::sir_src_t next_src;
   logic [sir_pkg::CNT_W-1:0] cnt;
   logic [sir_pkg::CNT_W-1:0] delay_last;
   logic [2:0] drive_hist;
   logic lvd_active;
   logic wdg_req;
   logic ext_req;
   logic wdg_done;
   logic delay_done;
   logic fetch_done;
   logic enter_lvd;
   logic enter_wdg;
   logic enter_ext;
   logic run;

   // Comparator carries the hysteresis, so its level is the reset
   assign lvd_active = s_lvd & s_opt_en; // [R3]
   assign wdg_req = i_watchdog_underflow & (state == sir_pkg::ST_RUN);
   // Our own drive echoes back through the synchroniser; ignore it
   assign ext_req = ~s_pin & ~o_reset_pin_oe & ~(|drive_hist);
   assign delay_last = s_opt_long ? sir_pkg::CNT_W'(sir_pkg::DELAY_LONG_CYC - 1)
                                  : sir_pkg::CNT_W'(sir_pkg::DELAY_SHORT_CYC - 1); // [R17]
   assign wdg_done = cnt == sir_pkg::CNT_W'(sir_pkg::WDG_PULSE_CYC - 1);
   assign delay_done = cnt == delay_last;
   assign fetch_done = cnt == sir_pkg::CNT_W'(sir_pkg::FETCH_CYC - 1); // [R18]
   // A dip that returns in delay or fetch restarts the whole sequence
   assign enter_lvd = lvd_active & ~(state == sir_pkg::ST_ACTIVE && src == sir_pkg::SRC_LVD); // [R3]
   assign enter_wdg = wdg_req & ~enter_lvd;
   assign enter_ext = ext_req & (state == sir_pkg::ST_RUN) & ~enter_lvd & ~wdg_req;
   assign run = state == sir_pkg::ST_RUN;

   // Next state; low supply overrides every other phase
   always_comb begin
      next_state = state;
      next_src = src;
      if (enter_lvd) begin
         next_state = sir_pkg::ST_ACTIVE;
         next_src = sir_pkg::SRC_LVD;
      end else if (enter_wdg) begin
         next_state = sir_pkg::ST_ACTIVE;
         next_src = sir_pkg::SRC_WDG;
      end else if (enter_ext) begin
         next_state = sir_pkg::ST_ACTIVE;
         next_src = sir_pkg::SRC_EXT;
      end else begin
         unique case (state)
            sir_pkg::ST_RUN: begin
               next_src = sir_pkg::SRC_NONE;
            end
            sir_pkg::ST_ACTIVE: begin
               unique case (src)
                  sir_pkg::SRC_LVD: if (!lvd_active) next_state = sir_pkg::ST_DELAY; // [R3]
                  sir_pkg::SRC_WDG: if (wdg_done) next_state = sir_pkg::ST_DELAY; // [R1]
                  sir_pkg::SRC_EXT: if (s_pin) next_state = sir_pkg::ST_DELAY;
                  sir_pkg::SRC_NONE: next_state = sir_pkg::ST_DELAY;
               endcase
            end
            sir_pkg::ST_DELAY: if (delay_done) next_state = sir_pkg::ST_FETCH; // [R17]
            sir_pkg::ST_FETCH: if (fetch_done) next_state = sir_pkg::ST_RUN; // [R18]
         endcase
      end
   end

   // Phase counter restarts on every phase change
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= sir_pkg::ST_ACTIVE;
         src <= sir_pkg::SRC_NONE;
         cnt <= '0;
         drive_hist <= 3'h7;
      end else begin
         state <= next_state;
         src <= next_src;
         cnt <= (next_state != state || next_src != src) ? '0 : cnt + 1'b1;
         drive_hist <= {drive_hist[1:0], o_reset_pin_oe};
      end
   end

   // External sources only sense the pin while active, all others drive it; every source drives it in delay
   assign o_reset_pin_oe = (state == sir_pkg::ST_DELAY) |
                           (state == sir_pkg::ST_ACTIVE && src != sir_pkg::SRC_EXT); // [R1] [R2] [R17]
   assign o_reset_pin_out = 1'b0;
   assign o_cpu_reset_n = run;
   assign o_vector_fetch = state == sir_pkg::ST_FETCH; // [R18]

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic aw_got;
   logic w_got;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic rd_fire;
   logic wr_mapped;
   logic rd_mapped;
   logic wr_ics;
   logic wr_stat;
   logic wr_mask;
   logic [31:0] rd_value;

   assign o_s_axi_awready = ~aw_got & ~o_s_axi_bvalid;
   assign o_s_axi_wready = ~w_got & ~o_s_axi_bvalid;
   assign o_s_axi_arready = ~o_s_axi_rvalid;
   assign wr_fire = aw_got & w_got & ~o_s_axi_bvalid;
   assign rd_fire = i_s_axi_arvalid & o_s_axi_arready;
   // Only the low lane carries register data
   assign wr_ics = wr_fire & w_strb[0] & (aw_addr == sir_pkg::ADDR_ICS) & ~i_halt; // [R9]
   assign wr_stat = wr_fire & w_strb[0] & (aw_addr == sir_pkg::ADDR_EVT_STAT);
   assign wr_mask = wr_fire & w_strb[0] & (aw_addr == sir_pkg::ADDR_EVT_MASK);
   assign wr_mapped = aw_addr == sir_pkg::ADDR_ICS || aw_addr == sir_pkg::ADDR_EVT_STAT ||
                      aw_addr == sir_pkg::ADDR_EVT_MASK || aw_addr == sir_pkg::ADDR_SEQ;
   assign rd_mapped = i_s_axi_araddr == sir_pkg::ADDR_ICS || i_s_axi_araddr == sir_pkg::ADDR_EVT_STAT ||
                      i_s_axi_araddr == sir_pkg::ADDR_EVT_MASK || i_s_axi_araddr == sir_pkg::ADDR_SEQ;

   // Address and data are taken in either order, response after both
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= sir_pkg::RESP_OKAY;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_got <= 1'b1;
            aw_addr <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_got <= 1'b1;
            w_data <= i_s_axi_wdata;
            w_strb <= i_s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= wr_mapped ? sir_pkg::RESP_OKAY : sir_pkg::RESP_SLVERR;
         end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data registered at the address handshake
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= '0;
         o_s_axi_rresp <= sir_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= rd_value;
         o_s_axi_rresp <= rd_mapped ? sir_pkg::RESP_OKAY : sir_pkg::RESP_SLVERR;
      end else if (i_s_axi_rready) begin
         o_s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Integrity control/status and warning interrupt
   // ------------------------------------------------------------
   sir_pkg::sir_ics_t ics;
   logic warn_level;
   logic en_prev;
   logic warn_toggle;
   logic en_rise;
   logic pend_set;
   logic pending;
   logic brown_clr;
   logic wdg_clr;

   // Monitor is dead unless the detector option is on
   assign warn_level = s_warn & s_opt_en; // [R4]
   // Flag is frozen in halt, so no change is seen there
   assign warn_toggle = run & ~i_halt & (warn_level != ics.warn_level_flag); // [R6] [R9]
   // Enabling while the flag shows low supply fires at once
   assign en_rise = run & ics.warn_irq_enable & ~en_prev & ics.warn_level_flag; // [R12]
   assign pend_set = (ics.warn_irq_enable & warn_toggle) | en_rise; // [R6] [R11]
   // Software clears a cause flag only by writing zero; reserved bits ignored
   assign brown_clr = wr_ics & ~w_data[sir_pkg::ICS_BROWNOUT_BIT]; // [R13] [R16]
   assign wdg_clr = wr_ics & ~w_data[sir_pkg::ICS_WATCHDOG_BIT]; // [R14]

   // Cause flags survive the sequence; hardware set wins over clear
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ics <= '0;
         en_prev <= 1'b0;
      end else begin
         en_prev <= ics.warn_irq_enable;
         if (!i_halt) begin
            ics.warn_level_flag <= warn_level; // [R5] [R9]
         end
         if (!run) begin
            ics.warn_irq_enable <= 1'b0;
         end else if (wr_ics) begin
            ics.warn_irq_enable <= w_data[sir_pkg::ICS_IRQ_EN_BIT];
         end
         if (enter_lvd) begin
            ics.brownout_reset_flag <= 1'b1; // [R13]
         end else if (brown_clr) begin
            ics.brownout_reset_flag <= 1'b0; // [R15]
         end
         if (enter_lvd) begin
            ics.watchdog_reset_flag <= 1'b0; // [R14]
         end else if (enter_wdg) begin
            ics.watchdog_reset_flag <= 1'b1; // [R14]
         end else if (wdg_clr) begin
            ics.watchdog_reset_flag <= 1'b0;
         end
      end
   end

   // Pending request; cleared by the sequencer and by service entry
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pending <= 1'b0;
      end else if (!run) begin
         pending <= 1'b0; // [R11]
      end else if (pend_set) begin
         pending <= 1'b1;
      end else if (i_warn_isr_enter) begin
         pending <= 1'b0; // [R7]
      end
   end

   assign o_warn_irq = pending & ics.warn_irq_enable & i_irq_unmasked; // [R8]
   // Wait wake only; halt is never left on this source
   assign o_wake_wait = o_warn_irq & i_wait & ~i_halt; // [R9] [R10]

   // ------------------------------------------------------------
   // Event status, mask and interrupt output
   // ------------------------------------------------------------
   sir_pkg::sir_evt_t evt_stat;
   sir_pkg::sir_evt_t evt_mask;
   sir_pkg::sir_evt_t evt_set;
   sir_pkg::sir_evt_t evt_clr;

   assign evt_set = '{warn_change: warn_toggle, ext_reset: enter_ext,
                      brownout_reset: enter_lvd, watchdog_reset: enter_wdg};
   assign evt_clr = wr_stat ? sir_pkg::sir_evt_t'(w_data[sir_pkg::EVT_W-1:0]) : sir_pkg::EVT_RESET;

   // Write one to clear; a same-cycle event keeps its bit
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         evt_stat <= sir_pkg::EVT_RESET;
         evt_mask <= sir_pkg::EVT_RESET;
      end else begin
         evt_stat <= (evt_stat & ~evt_clr) | evt_set;
         if (wr_mask) begin
            evt_mask <= sir_pkg::sir_evt_t'(w_data[sir_pkg::EVT_W-1:0]);
         end
      end
   end

   assign o_irq = |(evt_stat & evt_mask);

   // Read mux; reserved bits read zero
   always_comb begin
      rd_value = '0;
      unique case (i_s_axi_araddr)
         sir_pkg::ADDR_ICS: begin
            rd_value[sir_pkg::ICS_IRQ_EN_BIT] = ics.warn_irq_enable;
            rd_value[sir_pkg::ICS_LEVEL_BIT] = ics.warn_level_flag;
            rd_value[sir_pkg::ICS_BROWNOUT_BIT] = ics.brownout_reset_flag;
            rd_value[sir_pkg::ICS_WATCHDOG_BIT] = ics.watchdog_reset_flag;
         end
         sir_pkg::ADDR_EVT_STAT: rd_value[sir_pkg::EVT_W-1:0] = evt_stat;
         sir_pkg::ADDR_EVT_MASK: rd_value[sir_pkg::EVT_W-1:0] = evt_mask;
         sir_pkg::ADDR_SEQ: rd_value[5:0] = {s_opt_long, s_opt_en, src, state};
         default: rd_value = '0;
      endcase
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_wdg_start;
      enter_wdg && run;
   endsequence
   sequence s_enter_fetch;
      state == sir_pkg::ST_DELAY ##1 state == sir_pkg::ST_FETCH;
   endsequence

   property p_wdg_pulse;
      s_wdg_start |=> o_reset_pin_oe [*4];
   endproperty
   a_wdg_pulse: assert property (p_wdg_pulse) else $error("watchdog pulse too short"); // [R1]

   property p_lvd_pin;
      lvd_active |=> o_reset_pin_oe && !o_cpu_reset_n;
   endproperty
   a_lvd_pin: assert property (p_lvd_pin) else $error("pin released in low supply reset"); // [R2]

   property p_lvd_static;
      lvd_active |=> !o_cpu_reset_n;
   endproperty
   a_lvd_static: assert property (p_lvd_static) else $error("cpu runs in low supply"); // [R3]

   property p_warn_gate;
      !s_opt_en && !i_halt |=> !ics.warn_level_flag;
   endproperty
   a_warn_gate: assert property (p_warn_gate) else $error("warning active without detector"); // [R4]

   property p_flag_track;
      !i_halt |=> ics.warn_level_flag == $past(warn_level);
   endproperty
   a_flag_track: assert property (p_flag_track) else $error("level flag not tracking"); // [R5]

   property p_toggle_irq;
      ics.warn_irq_enable && warn_toggle |=> pending;
   endproperty
   a_toggle_irq: assert property (p_toggle_irq) else $error("toggle lost"); // [R6]

   property p_isr_clear;
      i_warn_isr_enter && !pend_set |=> !pending;
   endproperty
   a_isr_clear: assert property (p_isr_clear) else $error("pending not cleared"); // [R7]

   property p_irq_gate;
      o_warn_irq |-> ics.warn_irq_enable && i_irq_unmasked && pending;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("warning irq ungated"); // [R8]

   property p_halt_freeze;
      i_halt && run && !enter_lvd && !enter_wdg |-> !o_wake_wait ##1 $stable(ics);
   endproperty
   a_halt_freeze: assert property (p_halt_freeze) else $error("register moved in halt"); // [R9]

   property p_delay_len;
      s_enter_fetch |-> $past(cnt) == delay_last && $past(o_reset_pin_oe);
   endproperty
   a_delay_len: assert property (p_delay_len) else $error("reset delay wrong length"); // [R17]

   property p_fetch;
      $rose(o_vector_fetch) && !lvd_active |=> o_vector_fetch ##1 !o_vector_fetch;
   endproperty
   a_fetch: assert property (p_fetch) else $error("vector fetch not two cycles"); // [R18]

   property p_wdg_flag;
      enter_lvd |=> !ics.watchdog_reset_flag && ics.brownout_reset_flag;
   endproperty
   a_wdg_flag: assert property (p_wdg_flag) else $error("cause flags wrong on brownout"); // [R14]

endmodule

// [tb/sir_reset_line.sv]
// Reset line partner: pull-up, our open drain and an outside pull-down
`timescale 1ns/1ps
module sir_reset_line (
   input wire logic i_oe,
   input wire logic i_out,
   input wire logic i_ext_pull,
   output logic o_level
);
   // -------------------------------------
   // Wired level
   // -------------------------------------
   // Pull-up wins only when nobody sinks the line
   assign o_level = !((i_oe && !i_out) || i_ext_pull);
endmodule

// [tb/supply_integrity_reset_flags_bench.sv]
// Self-checking bench of the supply integrity block
`timescale 1ns/1ps
module supply_integrity_reset_flags_bench;
   logic clk = 1'b0, rst_n = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd;
   logic awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
   logic awr, wr_r, bv, arr, rv, oe, pout, lvl;
   logic [1:0] br, rr;
   logic [31:0] rdo;
   logic lsd = 0, swm = 0, wdg = 0, hlt = 0, wt = 0, unm = 1, isr = 0, ext = 0, opt_en = 1, opt_lg = 0;
   logic wirq, wake, cpu_n, vf, irq;
   int fails = 0, total_checks = 0, n_oe, n_vf;
   initial begin
      forever #2.5 clk = ~clk;
   end
   sir_integrity u_sir_integrity (.i_sys_clk(clk), .i_reset_n(rst_n), .i_s_axi_awaddr(awa),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'h1),
      .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_r), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
      .i_s_axi_bready(brd), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .o_s_axi_rdata(rdo), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rrd),
      .i_low_supply_detector(lsd), .i_supply_warning_monitor(swm), .i_opt_detector_enable(opt_en),
      .i_opt_long_delay(opt_lg), .i_reset_pin(lvl), .o_reset_pin_out(pout), .o_reset_pin_oe(oe),
      .i_watchdog_underflow(wdg), .i_halt(hlt), .i_wait(wt), .i_irq_unmasked(unm),
      .i_warn_isr_enter(isr), .o_warn_irq(wirq), .o_wake_wait(wake), .o_cpu_reset_n(cpu_n),
      .o_vector_fetch(vf), .o_irq(irq));
   sir_reset_line u_sir_reset_line (.i_oe(oe), .i_out(pout), .i_ext_pull(ext), .o_level(lvl));
   // -------------------------------------
   // Shared tasks
   // -------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Sample at the falling edge, act by NBA after the rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ha, hw, hb;
      @(posedge clk);
      awa <= a; wd <= d; awv <= 1; wv <= 1; brd <= 1;
      forever begin
         @(negedge clk);
         ha = awv && awr; hw = wv && wr_r; hb = bv;
         if (hb) chk("bresp", {30'h0, er}, {30'h0, br});
         @(posedge clk);
         if (ha) awv <= 0;
         if (hw) wv <= 0;
         if (hb) break;
      end
      brd <= 0;
   endtask
   task automatic rdk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ha, hr;
      @(posedge clk);
      ara <= a; arv <= 1; rrd <= 1;
      forever begin
         @(negedge clk);
         ha = arv && arr; hr = rv;
         if (hr) begin
            chk("rdata", e, rdo);
            chk("rresp", {30'h0, er}, {30'h0, rr});
         end
         @(posedge clk);
         if (ha) arv <= 0;
         if (hr) break;
      end
      rrd <= 0;
   endtask
   task automatic run_wait();
      n_oe = 0; n_vf = 0;
      for (int i = 0; i < 6000; i++) begin
         @(negedge clk);
         if (cpu_n === 1'b1) break;
         if (oe === 1'b1) n_oe++;
         if (vf === 1'b1) n_vf++;
      end
      chk("cpu_released", 1, cpu_n);
   endtask
   task automatic wrap_up();
      if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // -------------------------------------
   // Scenarios
   // -------------------------------------
   task automatic t_watchdog();
      @(posedge clk) wdg <= 1;
      @(posedge clk) wdg <= 0;
      run_wait();
      chk("oe_cycles", 32'd260, n_oe);
      chk("fetch_cycles", 32'd2, n_vf);
      rdk(8'h00, 32'h01, 2'h0);
      wr(8'h08, 32'h1, 2'h0);
      chk("irq_on", 1, irq);
      wr(8'h04, 32'h1, 2'h0);
      chk("irq_cleared", 0, irq);
      rdk(8'h10, 32'h0, 2'h2);
   endtask
   task automatic t_low_supply();
      @(posedge clk) lsd <= 1;
      repeat (40) @(posedge clk);
      chk("oe_held", 1, oe);
      chk("cpu_held", 0, cpu_n);
      chk("pin_low", 0, lvl);
      lsd <= 0;
      run_wait();
      rdk(8'h00, 32'h10, 2'h0);
      @(posedge clk) ext <= 1;
      repeat (10) @(posedge clk);
      ext <= 0;
      run_wait();
      chk("ext_took", 32'd256, n_oe);
      rdk(8'h00, 32'h10, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
      rdk(8'h00, 32'h00, 2'h0);
   endtask
   task automatic t_warning();
      @(posedge clk) swm <= 1;
      repeat (6) @(posedge clk);
      rdk(8'h00, 32'h20, 2'h0);
      chk("no_irq_off", 0, wirq);
      wr(8'h00, 32'h40, 2'h0);
      repeat (2) @(posedge clk);
      chk("irq_on_enable", 1, wirq);
      @(posedge clk) isr <= 1;
      @(posedge clk) isr <= 0;
      @(negedge clk) chk("isr_clear", 0, wirq);
      @(posedge clk) begin swm <= 0; unm <= 0; wt <= 1; end
      repeat (6) @(posedge clk);
      chk("masked", 0, wirq);
      unm <= 1;
      @(negedge clk) chk("irq_falling", 1, wirq);
      chk("wake", 1, wake);
      rdk(8'h00, 32'h40, 2'h0);
      @(posedge clk) isr <= 1;
      @(posedge clk) begin isr <= 0; swm <= 1; end
      @(negedge clk) chk("isr_clear_2", 0, wirq);
      repeat (6) @(posedge clk);
      chk("irq_rising", 1, wirq);
      // Level moves in halt but the flag must not follow
      @(posedge clk) begin hlt <= 1; swm <= 0; end
      wr(8'h00, 32'h0, 2'h0);
      rdk(8'h00, 32'h60, 2'h0);
      chk("no_halt_wake", 0, wake);
   endtask
   task automatic t_options();
      @(posedge clk) begin hlt <= 0; opt_en <= 0; lsd <= 1; swm <= 1; end
      repeat (6) @(posedge clk);
      chk("no_detector", 1, cpu_n);
      rdk(8'h00, 32'h40, 2'h0);
   endtask
   task automatic t_long_delay();
      @(posedge clk) begin opt_en <= 1; opt_lg <= 1; lsd <= 0; end
      repeat (6) @(posedge clk);
      @(posedge clk) wdg <= 1;
      // Supply recovers while the sequencer still holds reset
      @(posedge clk) begin wdg <= 0; swm <= 0; end
      run_wait();
      chk("oe_long", 32'd4100, n_oe);
      chk("fetch_long", 32'd2, n_vf);
      wr(8'h00, 32'h40, 2'h0);
      repeat (3) @(posedge clk);
      chk("no_irq_delay", 0, wirq);
   endtask
   // -------------------------------------
   // Main sequence and watchdog
   // -------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      run_wait();
      rdk(8'h00, 32'h00, 2'h0);
      t_watchdog();
      t_low_supply();
      t_warning();
      t_options();
      t_long_delay();
      wrap_up();
   end
   initial begin
      #400000;
      fails++;
      wrap_up();
   end
endmodule
